// *** rtl/sfx_top.sv ***
// Adapter-side select-feedback exception handling and channel reset state.
// Assumes channel pins are synchronous to CLK_SYS; bus values are resolved outside.
// How it works
// - A transfer ending without select-feedback return is an exception.
// - The enable input gates miss reporting; cleared means no miss is reported, though channel check still is.
// - Return line state is captured on any exception, enabled or not.
// - Bus master raises an interrupt, halting the transfer on the same edge when HALT_ON_MISS is set.
// - Status shown with the interrupt flags the missing return.
// - Data after a detected miss is marked untrustworthy.
// - DMA role records status and asserts terminal count when slave selected.
// - Terminal count may instead be asserted on a later operation with slave.
// - Channel reset forces every state into a defined initial value.
// - During and after reset, address, data and arbitration drivers float.
// - During and after reset, interrupt, channel check and status outputs idle.
// - Reserved channel lines are neither driven nor sampled.
// - Narrow connector allows 8/16-bit transfers; wide adds 24 and 32.
`timescale 1ns/1ns
`include "sfx_defs.svh"
module sfx_top
   import sfx_pkg::*;
(
   input  wire logic                     CLK_SYS,
   input  wire logic                     RST,
   input  wire logic                     SFX_EN,
   input  wire logic                     HALT_ON_MISS,
   input  wire logic                     TC_DEFER,
   input  wire logic                     WIDE_SLOT,
   input  wire logic [1:0]               ROLE,
   input  wire logic                     XFER_REQ,
   input  wire logic [2:0]               XFER_BYTES,
   input  wire logic                     XFER_LAST,
   input  wire logic                     XFER_DONE,
   input  wire logic                     DMA_SLAVE_SEL,
   input  wire logic                     SELECT_FEEDBACK_RETURN_N,
   input  wire logic                     CHANNEL_CHECK_REQ,
   input  wire logic                     STATUS_CLEAR,
   input  wire logic [`SFX_ADDR_W-1:0]   ADDR_IN,
   input  wire logic [`SFX_DATA_W-1:0]   DATA_IN,
   input  wire logic [`SFX_ARB_W-1:0]    ARB_IN,
   output logic [`SFX_ADDR_W-1:0]        ADDR_OUT,
   output logic                          ADDR_OE,
   output logic [`SFX_DATA_W-1:0]        DATA_OUT,
   output logic                          DATA_OE,
   output logic [`SFX_ARB_W-1:0]         ARB_OUT,
   output logic                          ARB_OE,
   output logic                          TERMINAL_COUNT_N,
   output logic                          TERMINAL_COUNT_OE,
   output logic                          IRQ_N,
   output logic                          CHANNEL_CHECK_N,
   output logic                          XFER_ACCEPT,
   output logic                          XFER_ABORT,
   output logic                          DATA_SUSPECT,
   output logic [`SFX_STS_W-1:0]         STATUS,
   output logic                          RTN_STATE
);
   sfx_state_t                state_q;
   sfx_state_t                state_d;
   logic                      seen_q;
   logic [`SFX_STS_W-1:0]     sts_q;
   logic                      rtn_q;
   logic                      irq_q;
   logic                      suspect_q;
   logic                      chk_q;
   logic                      drive_q;
   logic                      abort_q;
   logic [`SFX_ADDR_W-1:0]    addr_q;
   logic [`SFX_DATA_W-1:0]    data_q;
   logic                      miss;
   logic                      exc_any;
   logic                      size_ok;
   logic                      tc_oe;
   logic                      op_start;

   // Byte counts 1..2 fit either slot; 3..4 need the wide connector
   function automatic logic size_legal(input logic wide, input logic [2:0] n);
      size_legal = (n == 3'd1) || (n == 3'd2) || (wide && ((n == 3'd3) || (n == 3'd4)));
   endfunction : size_legal

   assign size_ok  = size_legal(WIDE_SLOT, XFER_BYTES);
   assign op_start = (state_q == SFX_IDLE) && XFER_REQ && size_ok
                     && (ROLE != SFX_ROLE_NONE);
   // Miss judged at transfer end: return never went low while selected
   assign miss     = (state_q == SFX_CHECK) && !seen_q;
   assign exc_any  = miss || CHANNEL_CHECK_REQ;

   always_comb begin
      state_d = state_q;
      case (state_q)
         SFX_IDLE: begin
            if (op_start) begin
               state_d = SFX_XFER;
            end
         end
         SFX_XFER: begin
            if (XFER_DONE) begin
               state_d = SFX_CHECK;
            end
         end
         SFX_CHECK: begin
            state_d = SFX_END;
         end
         SFX_END: begin
            state_d = SFX_IDLE;
         end
         default: begin
            state_d = SFX_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         state_q <= SFX_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         seen_q <= 1'b0;
      end else if (op_start) begin
         seen_q <= 1'b0;
      end else if (state_q == SFX_XFER && !SELECT_FEEDBACK_RETURN_N) begin
         seen_q <= 1'b1;
      end
   end

   // Return state is captured on every exception, reporting or not
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rtn_q <= 1'b0;
      end else if (exc_any) begin
         rtn_q <= seen_q;
      end
   end

   // Miss and role status bits are sticky, the return bit follows rtn_q; a new event wins over a same-cycle clear
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         sts_q <= `SFX_ZERO_STS;
      end else if (miss && SFX_EN) begin
         sts_q[`SFX_STS_MISS] <= 1'b1;
         sts_q[`SFX_STS_RTN]  <= 1'b0;
         sts_q[`SFX_STS_DMA]  <= (ROLE == SFX_ROLE_DMA);
         sts_q[`SFX_STS_BM]   <= (ROLE == SFX_ROLE_BM);
      end else if (STATUS_CLEAR) begin
         sts_q <= `SFX_ZERO_STS;
      end else begin
         sts_q[`SFX_STS_RTN] <= rtn_q;
      end
   end

   // Interrupt only for the bus-master role; DMA reports via terminal count
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         irq_q <= 1'b0;
      end else if (miss && SFX_EN && ROLE == SFX_ROLE_BM) begin
         irq_q <= 1'b1;
      end else if (STATUS_CLEAR) begin
         irq_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         suspect_q <= 1'b0;
      end else if (miss && SFX_EN) begin
         suspect_q <= 1'b1;
      end else if (op_start) begin
         suspect_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         abort_q <= 1'b0;
      end else begin
         abort_q <= miss && SFX_EN && HALT_ON_MISS && ROLE == SFX_ROLE_BM;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         chk_q <= 1'b0;
      end else if (CHANNEL_CHECK_REQ) begin
         chk_q <= 1'b1;
      end else if (STATUS_CLEAR) begin
         chk_q <= 1'b0;
      end
   end

   // Drivers float until a legal transfer starts; reserved lines have no port
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         drive_q <= 1'b0;
         addr_q  <= '0;
         data_q  <= '0;
      end else begin
         drive_q <= (state_d == SFX_XFER);
         if (op_start) begin
            addr_q <= WIDE_SLOT ? ADDR_IN
                      : {{(`SFX_ADDR_W-`SFX_ADDR_NARROW){1'b0}},
                         ADDR_IN[`SFX_ADDR_NARROW-1:0]};
            data_q <= WIDE_SLOT ? DATA_IN
                      : {{(`SFX_DATA_W-`SFX_DATA_NARROW){1'b0}},
                         DATA_IN[`SFX_DATA_NARROW-1:0]};
         end
      end
   end

   sfx_tc_ctl u_tc (
      .clk       (CLK_SYS),
      .rst       (RST),
      .defer_en  (TC_DEFER),
      .exc_pulse (miss && SFX_EN && ROLE == SFX_ROLE_DMA),
      .slave_sel (DMA_SLAVE_SEL),
      .op_start  (op_start && ROLE == SFX_ROLE_DMA),
      .tc_oe     (tc_oe)
   );

   assign ADDR_OUT          = addr_q;
   assign ADDR_OE           = drive_q;
   assign DATA_OUT          = data_q;
   assign DATA_OE           = drive_q && !(abort_q || XFER_LAST && suspect_q);
   assign ARB_OUT           = '0;
   assign ARB_OE            = 1'b0;
   assign TERMINAL_COUNT_N  = 1'b0;
   assign TERMINAL_COUNT_OE = tc_oe;
   assign IRQ_N             = !irq_q;
   assign CHANNEL_CHECK_N   = !chk_q;
   assign XFER_ACCEPT       = op_start;
   assign XFER_ABORT        = abort_q;
   assign DATA_SUSPECT      = suspect_q;
   assign STATUS            = sts_q;
   assign RTN_STATE         = rtn_q;
   // ARB_IN is deliberately unused: arbitration is outside this block
   logic unused_arb;
   assign unused_arb = ^ARB_IN;
endmodule : sfx_top

// *** shared/sfx_defs.svh ***
// Constants for the select-feedback exception and reset block.
// Assumes inclusion by bare name from the rtl and bench files.
`ifndef SFX_DEFS_SVH
`define SFX_DEFS_SVH
`define SFX_ADDR_W      32
`define SFX_DATA_W      32
`define SFX_ARB_W       4
`define SFX_ADDR_NARROW 24
`define SFX_DATA_NARROW 16
`define SFX_STS_W       4
`define SFX_STS_MISS    0
`define SFX_STS_RTN     1
`define SFX_STS_DMA     2
`define SFX_STS_BM      3
`define SFX_ZERO_STS    4'h0
`endif

// *** shared/sfx_pkg.sv ***
// Types for the select-feedback exception and reset block.
// Assumes sfx_defs.svh is on the include path.
package sfx_pkg;
   typedef enum logic [3:0] {
      SFX_IDLE  = 4'b0001,
      SFX_XFER  = 4'b0010,
      SFX_CHECK = 4'b0100,
      SFX_END   = 4'b1000
   } sfx_state_t;
   typedef enum logic [1:0] {
      SFX_ROLE_NONE = 2'b00,
      SFX_ROLE_BM   = 2'b01,
      SFX_ROLE_DMA  = 2'b10
   } sfx_role_t;
endpackage : sfx_pkg

// *** rtl/sfx_tc_ctl.sv ***
// Terminal-count driver for the DMA role, immediate or deferred.
// Assumes one clock; requests are one-cycle pulses from the main block.
`timescale 1ns/1ns
`include "sfx_defs.svh"
module sfx_tc_ctl
   import sfx_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic defer_en,
   input  wire logic exc_pulse,
   input  wire logic slave_sel,
   input  wire logic op_start,
   output logic      tc_oe
);
   logic pend_q;
   logic tc_q;

   // Pending request stays until the next operation with the same slave
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_q <= 1'b0;
      end else if (exc_pulse && (defer_en || !slave_sel)) begin
         pend_q <= 1'b1;
      end else if (op_start && slave_sel) begin
         pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tc_q <= 1'b0;
      end else begin
         tc_q <= (exc_pulse && slave_sel && !defer_en)
                 || (pend_q && op_start && slave_sel);
      end
   end

   assign tc_oe = tc_q;
endmodule : sfx_tc_ctl

// *** bench/sfx_checker.sv ***
// Port checker for sfx_top, attached by bind.
// Assumes one clock domain with an active-high asynchronous reset.
`timescale 1ns/1ns
`include "sfx_defs.svh"
module sfx_checker
   import sfx_pkg::*;
(
   input wire logic        CLK_SYS,
   input wire logic        RST,
   input wire logic        SFX_EN,
   input wire logic        HALT_ON_MISS,
   input wire logic        WIDE_SLOT,
   input wire logic [1:0]  ROLE,
   input wire logic [2:0]  XFER_BYTES,
   input wire logic        DMA_SLAVE_SEL,
   input wire logic        XFER_ACCEPT,
   input wire logic [31:0] ADDR_OUT,
   input wire logic        ADDR_OE,
   input wire logic        DATA_OE,
   input wire logic        ARB_OE,
   input wire logic        TERMINAL_COUNT_N,
   input wire logic        TERMINAL_COUNT_OE,
   input wire logic        IRQ_N,
   input wire logic        CHANNEL_CHECK_N,
   input wire logic        XFER_ABORT,
   input wire logic [3:0]  STATUS
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // Reset checks must stay live while reset is high
   property p_rst_float;
      disable iff (1'b0) RST |-> !(ADDR_OE || DATA_OE || ARB_OE || TERMINAL_COUNT_OE);
   endproperty
   a_rst_float: assert property (p_rst_float) else $error("driver on in reset");
   property p_rst_idle;
      disable iff (1'b0) RST |-> IRQ_N && CHANNEL_CHECK_N && STATUS == 4'h0;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("output busy in reset");
   property p_no_rpt;
      $fell(IRQ_N) |-> $past(SFX_EN);
   endproperty
   a_no_rpt: assert property (p_no_rpt) else $error("report while off");
   property p_irq_sts;
      $fell(IRQ_N) |-> STATUS[`SFX_STS_MISS] && STATUS[`SFX_STS_BM];
   endproperty
   a_irq_sts: assert property (p_irq_sts) else $error("irq without status");
   property p_tc;
      TERMINAL_COUNT_OE |-> !TERMINAL_COUNT_N && DMA_SLAVE_SEL ##1 !TERMINAL_COUNT_OE;
   endproperty
   a_tc: assert property (p_tc) else $error("bad terminal count");
   property p_narrow_sz;
      XFER_ACCEPT && !WIDE_SLOT |-> XFER_BYTES inside {3'h1, 3'h2} && ROLE != 2'h0;
   endproperty
   a_narrow_sz: assert property (p_narrow_sz) else $error("bad size taken");
   property p_narrow_addr;
      ADDR_OE && !WIDE_SLOT |-> ADDR_OUT[31:24] == 8'h00;
   endproperty
   a_narrow_addr: assert property (p_narrow_addr) else $error("wide address");
   property p_abort;
      XFER_ABORT |-> HALT_ON_MISS && ROLE == SFX_ROLE_BM ##1 !XFER_ABORT;
   endproperty
   a_abort: assert property (p_abort) else $error("bad abort");
   c_irq: cover property ($fell(IRQ_N));
   c_tc: cover property (TERMINAL_COUNT_OE);
   c_abort: cover property (XFER_ABORT);
endmodule : sfx_checker
bind sfx_top sfx_checker u_chk (.CLK_SYS, .RST, .SFX_EN, .HALT_ON_MISS, .WIDE_SLOT, .ROLE,
   .XFER_BYTES, .DMA_SLAVE_SEL, .XFER_ACCEPT, .ADDR_OUT, .ADDR_OE, .DATA_OE, .ARB_OE,
   .TERMINAL_COUNT_N, .TERMINAL_COUNT_OE, .IRQ_N, .CHANNEL_CHECK_N, .XFER_ABORT, .STATUS);

// *** bench/sfx_chan_model.sv ***
// Far side of the channel: returns select feedback and ends each transfer.
// Assumes start is the adapter's accept strobe, taken at the rising edge.
`timescale 1ns/1ns
module sfx_chan_model (
   input  wire logic       clk,
   input  wire logic       start,
   input  wire logic       miss,
   input  wire logic [2:0] lat,
   output logic            rtn_n,
   output logic            done
);
   initial begin
      rtn_n = 1'b1;
      done  = 1'b0;
      forever begin
         @(posedge clk);
         if (start) begin
            repeat (lat) @(negedge clk);
            // A commanded miss leaves the pulled-up line high throughout
            rtn_n = miss;
            @(negedge clk);
            rtn_n = 1'b1;
            done  = 1'b1;
            @(negedge clk);
            done  = 1'b0;
         end
      end
   end
endmodule : sfx_chan_model

// *** bench/tb_select_feedback_exception_and_reset.sv ***
// Self-checking bench for sfx_top with a far-side model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ns
`include "sfx_defs.svh"
module tb_select_feedback_exception_and_reset;
   import sfx_pkg::*;
   logic        clk, rst, en, halt, defer, wide, req, last, done, sel, rtn_n, chk, clr, miss;
   logic        acc, tc_oe, abrt, irq_n, chk_n, aoe, doe, boe, susp, rtn_st, pend_m;
   logic [1:0]  role;
   logic [2:0]  bytes, lat;
   logic [31:0] ain, din, aout, dout;
   logic [3:0]  arb, sts, arbo;
   int          miscompares, cmp_count, tcs, abs, exp_tc;
   sfx_top DUT (.CLK_SYS(clk), .RST(rst), .SFX_EN(en), .HALT_ON_MISS(halt),
      .TC_DEFER(defer), .WIDE_SLOT(wide), .ROLE(role), .XFER_REQ(req), .XFER_BYTES(bytes),
      .XFER_LAST(last), .XFER_DONE(done), .DMA_SLAVE_SEL(sel),
      .SELECT_FEEDBACK_RETURN_N(rtn_n), .CHANNEL_CHECK_REQ(chk), .STATUS_CLEAR(clr),
      .ADDR_IN(ain), .DATA_IN(din), .ARB_IN(arb), .ADDR_OUT(aout), .ADDR_OE(aoe),
      .DATA_OUT(dout), .DATA_OE(doe), .ARB_OUT(arbo), .ARB_OE(boe), .TERMINAL_COUNT_N(),
      .TERMINAL_COUNT_OE(tc_oe), .IRQ_N(irq_n), .CHANNEL_CHECK_N(chk_n),
      .XFER_ACCEPT(acc), .XFER_ABORT(abrt), .DATA_SUSPECT(susp), .STATUS(sts),
      .RTN_STATE(rtn_st));
   sfx_chan_model u_far (.clk(clk), .start(acc), .miss(miss), .lat(lat), .rtn_n(rtn_n),
      .done(done));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (tc_oe === 1'b1) tcs++;
      if (abrt === 1'b1) abs++;
   end
   task automatic chk_bit(input logic got, input logic exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk_bit
   task automatic chk_val(input logic [3:0] got, input logic [3:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk_val
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk_word
   // A narrow slot only carries the low lines of each bus
   function automatic logic [31:0] fit_bus(input logic [31:0] v, input logic w, input int nb);
      fit_bus = w ? v : v & ((32'h1 << nb) - 32'h1);
   endfunction : fit_bus
   task automatic xfer(input logic ok);
      logic b;
      int   n;
      tcs = 0;
      abs = 0;
      n   = 0;
      exp_tc = 0;
      @(negedge clk);
      ain = $urandom;
      din = $urandom;
      req = 1'b1;
      #1 b = acc;
      @(negedge clk) req = 1'b0;
      chk_bit(b, ok, "accept");
      if (ok) begin
         chk_bit(aoe & doe & !boe, 1'b1, "drivers in transfer");
         chk_word(aout, fit_bus(ain, wide, `SFX_ADDR_NARROW), "address");
         chk_word(dout, fit_bus(din, wide, `SFX_DATA_NARROW), "data");
         chk_val(arbo, 4'h0, "arbitration idle");
         // A count left pending by an earlier miss fires as this operation starts
         if (role == SFX_ROLE_DMA && sel) begin
            exp_tc = pend_m;
            pend_m = 1'b0;
         end
         while (done !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
         end
         repeat (4) @(negedge clk);
         if (role == SFX_ROLE_DMA && miss && en) begin
            if (defer || !sel) pend_m = 1'b1;
            else exp_tc++;
         end
      end
   endtask : xfer
   task automatic judge();
      logic rep;
      rep = miss & en;
      chk_val(sts & 4'hd, {rep & role[0], rep & role[1], 1'b0, rep}, "status");
      chk_bit(irq_n, !(rep & role[0]), "irq");
      chk_val(4'(tcs), 4'(exp_tc), "terminal count");
      chk_bit(susp, rep, "suspect");
      chk_val(4'(abs), {3'h0, rep & role[0] & halt}, "abort");
   endtask : judge
   task automatic clear();
      clr = 1'b1;
      @(negedge clk) clr = 1'b0;
      @(negedge clk);
      chk_bit(irq_n, 1'b1, "irq clear");
      chk_val(sts, 4'h0, "status clear");
   endtask : clear
   task automatic conclude();
      $display("compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   initial begin
      #(40 * 6000);
      miscompares++;
      conclude();
   end
   initial begin
      {en, halt, defer, wide, req, last, sel, chk, clr, miss} = 10'h000;
      {role, bytes, lat, ain, din, arb} = '0;
      {miscompares, cmp_count, tcs, abs} = '0;
      pend_m = 1'b0;
      exp_tc = 0;
      rst = 1'b1;
      void'($urandom(32'h9b2f));
      repeat (10) @(negedge clk);
      rst = 1'b0;
      bytes = 3'h1;
      lat = 3'h2;
      xfer(1'b0);
      role = SFX_ROLE_BM;
      for (int b = 3; b < 5; b++) begin
         bytes = 3'(b);
         xfer(1'b0);
      end
      $display("test refusals done");
      for (int i = 0; i < 40; i++) begin
         {miss, en, halt, sel, wide, last} = 6'($urandom);
         role = 2'($urandom_range(1, 2));
         arb = 4'($urandom);
         lat = 3'($urandom_range(1, 5));
         bytes = 3'($urandom_range(1, wide ? 4 : 2));
         xfer(1'b1);
         judge();
         clear();
      end
      $display("test random transfers done");
      role = SFX_ROLE_DMA;
      {miss, en, defer, sel} = 4'hf;
      xfer(1'b1);
      chk_val(4'(tcs), 4'(exp_tc), "tc held back");
      judge();
      miss = 1'b0;
      xfer(1'b1);
      chk_val(4'(tcs), 4'h1, "tc on next op");
      defer = 1'b0;
      clear();
      $display("test deferred count done");
      role = SFX_ROLE_BM;
      // Return seen on this transfer, so the check event must capture it as seen
      {miss, en, lat} = {2'h1, 3'h3};
      xfer(1'b1);
      chk = 1'b1;
      @(negedge clk) chk = 1'b0;
      chk_bit(chk_n, 1'b0, "check set");
      chk_bit(rtn_st, 1'b1, "return captured");
      req = 1'b1;
      @(negedge clk) req = 1'b0;
      @(negedge clk) chk_bit(aoe, 1'b1, "driving in transfer");
      rst = 1'b1;
      #1 chk_bit(aoe | doe | boe | tc_oe, 1'b0, "float");
      chk_bit(irq_n & chk_n, 1'b1, "idle outputs");
      chk_val(sts, 4'h0, "status reset");
      repeat (10) @(negedge clk);
      rst = 1'b0;
      $display("test reset done");
      conclude();
   end
endmodule : tb_select_feedback_exception_and_reset
